// *** hw/sdf_pkg.sv ***
// Package for the serial converter input frame block: constants and carrier types.
// Assumes one system clock (ref_clk, 10 MHz) that oversamples the serial link pins.
// Overview of operation
// - Frame select low enables input shifting
// - Shift data on each falling serial clock up to the sixteenth
// - Update converter on sixteenth falling edge
// - Early frame select rise aborts frame
// - Reset holds output code at zero
// - Converter code register is ten bits
package sdf_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS  = 10;
  localparam int CNT_BITS   = 5;
  localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;
  localparam logic [CNT_BITS-1:0] CNT_LAST  = 5'h0f;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 10'h000;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
  // Code field sits above two low don't-care bits of the frame
  localparam int CODE_LSB = 2;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    SDF_IDLE  = 2'b00,
    SDF_SHIFT = 2'b01,
    SDF_DONE  = 2'b11
  } sdf_state_type;

  // Pin group of the serial link, before and after synchronisation
  typedef struct packed {
    logic frameSelN;
    logic serialClk;
    logic serialData;
  } sdf_link_type;
endpackage : sdf_pkg

// *** hw/sdf_sync.sv ***
// Two flip-flop synchroniser for a group of link pins.
// Assumes inputs are asynchronous to ref_clk; first stage feeds only the second.
module sdf_sync (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic                 clkEn,
  input  wire sdf_pkg::sdf_link_type pinIn,
  output sdf_pkg::sdf_link_type     pinOut
);
  sdf_pkg::sdf_link_type stage1;
  sdf_pkg::sdf_link_type next_stage1;
  sdf_pkg::sdf_link_type next_pinOut;

  // Hold both stages while the clock enable is low
  always_comb begin
    next_stage1 = clkEn ? pinIn : stage1;
    next_pinOut = clkEn ? stage1 : pinOut;
  end

  // Reset value is frame idle: select high, clock high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '{frameSelN: 1'b1, serialClk: 1'b1, serialData: 1'b0};
      pinOut <= '{frameSelN: 1'b1, serialClk: 1'b1, serialData: 1'b0};
    end else begin
      stage1 <= next_stage1;
      pinOut <= next_pinOut;
    end
  end
endmodule // sdf_sync

// *** hw/sdf_frame.sv ***
// Serial input frame receiver for a 10-bit voltage-output converter.
// Assumes ref_clk is much faster than the serial clock so every pin edge is seen.
module sdf_frame (
  input  wire logic                          ref_clk,
  input  wire logic                          resetn,
  input  wire logic                          clkEn,
  input  wire logic                          frameSelN,
  input  wire logic                          serialClk,
  input  wire logic                          serialData,
  output logic [sdf_pkg::CODE_BITS-1:0]      analogOutputCode,
  output logic                               codeUpdate,
  output logic                               frameAbort
);
  sdf_pkg::sdf_link_type linkPins;
  sdf_pkg::sdf_link_type linkSync;
  assign linkPins = '{frameSelN: frameSelN, serialClk: serialClk, serialData: serialData};

  // Every pin is asynchronous, so all pass two flops first
  sdf_sync u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .pinIn   (linkPins),
    .pinOut  (linkSync)
  );

  sdf_pkg::sdf_state_type                state;
  sdf_pkg::sdf_state_type                next_state;
  logic                                  clkPrev;
  logic                                  next_clkPrev;
  logic [sdf_pkg::FRAME_BITS-1:0]        shiftReg;
  logic [sdf_pkg::FRAME_BITS-1:0]        next_shiftReg;
  logic [sdf_pkg::CNT_BITS-1:0]          bitCnt;
  logic [sdf_pkg::CNT_BITS-1:0]          next_bitCnt;
  logic [sdf_pkg::CODE_BITS-1:0]         next_analogOutputCode;
  logic                                  next_codeUpdate;
  logic                                  next_frameAbort;
  logic                                  clkFall;
  logic [sdf_pkg::FRAME_BITS-1:0]        fullWord;

  // Edge detect reads only the second synchroniser stage
  assign clkFall  = clkPrev & ~linkSync.serialClk;
  assign fullWord = {shiftReg[sdf_pkg::FRAME_BITS-2:0], linkSync.serialData};

  // Frame sequencer: shift, count, commit or abort
  always_comb begin
    next_state            = state;
    next_clkPrev          = linkSync.serialClk;
    next_shiftReg         = shiftReg;
    next_bitCnt           = bitCnt;
    next_analogOutputCode = analogOutputCode;
    next_codeUpdate       = 1'b0;
    next_frameAbort       = 1'b0;
    case (state)
      sdf_pkg::SDF_IDLE: begin
        // Clock and data are ignored while select is high
        if (!linkSync.frameSelN) begin
          next_state    = sdf_pkg::SDF_SHIFT;
          next_bitCnt   = sdf_pkg::CNT_RESET;
          next_shiftReg = sdf_pkg::SHIFT_RESET;
        end
      end
      sdf_pkg::SDF_SHIFT: begin
        if (linkSync.frameSelN) begin
          // Partial frame dropped, output left as it was
          next_state      = sdf_pkg::SDF_IDLE;
          next_frameAbort = 1'b1;
        end else if (clkFall) begin
          next_shiftReg = fullWord;
          next_bitCnt   = bitCnt + 5'h01;
          if (bitCnt == sdf_pkg::CNT_LAST) begin
            next_analogOutputCode =
              fullWord[sdf_pkg::CODE_LSB +: sdf_pkg::CODE_BITS];
            next_codeUpdate = 1'b1;
            next_state      = sdf_pkg::SDF_DONE;
          end
        end
      end
      sdf_pkg::SDF_DONE: begin
        // Extra clocks after the word are ignored until select rises
        if (linkSync.frameSelN) begin
          next_state = sdf_pkg::SDF_IDLE;
        end
      end
      default: begin
        next_state = sdf_pkg::SDF_IDLE;
      end
    endcase
  end

  // Register the sequencer; power-on code is zero volts
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state            <= sdf_pkg::SDF_IDLE;
      clkPrev          <= 1'b1;
      shiftReg         <= sdf_pkg::SHIFT_RESET;
      bitCnt           <= sdf_pkg::CNT_RESET;
      analogOutputCode <= sdf_pkg::CODE_RESET;
      codeUpdate       <= 1'b0;
      frameAbort       <= 1'b0;
    end else if (clkEn) begin
      state            <= next_state;
      clkPrev          <= next_clkPrev;
      shiftReg         <= next_shiftReg;
      bitCnt           <= next_bitCnt;
      analogOutputCode <= next_analogOutputCode;
      codeUpdate       <= next_codeUpdate;
      frameAbort       <= next_frameAbort;
    end
  end

  // Independent tally of falling edges in the current frame, read only by checks;
  // it guards the sequencer counter against an off-by-one at the word boundary
  logic [sdf_pkg::CNT_BITS-1:0]          fallTally;
  logic [sdf_pkg::CNT_BITS-1:0]          next_fallTally;

  // Tally clears while idle and counts accepted falls while shifting
  always_comb begin
    next_fallTally = fallTally;
    if (state == sdf_pkg::SDF_IDLE) begin
      next_fallTally = sdf_pkg::CNT_RESET;
    end else if (state == sdf_pkg::SDF_SHIFT && !linkSync.frameSelN && clkFall) begin
      next_fallTally = fallTally + 5'h01;
    end
  end

  // Tally register, frozen with the rest of the block
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fallTally <= sdf_pkg::CNT_RESET;
    end else if (clkEn) begin
      fallTally <= next_fallTally;
    end
  end

  // Output code only moves together with an update pulse
  a_code_only_update: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$stable(analogOutputCode) |-> codeUpdate)
    else $error("Output code changed without an update");

  // New code is the field of the word completed at the last fall
  a_update_takes_word: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(codeUpdate) |->
      analogOutputCode == $past(fullWord[sdf_pkg::CODE_LSB +: sdf_pkg::CODE_BITS]))
    else $error("Output code differs from the shifted word");

  // Update follows the fall that completes the sixteenth bit
  a_update_on_last: assert property (@(posedge ref_clk) disable iff (!resetn)
    codeUpdate |-> $past(bitCnt) == sdf_pkg::CNT_LAST && $past(clkFall))
    else $error("Update not on the sixteenth falling edge");

  // Update is a single-cycle pulse
  a_update_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
    codeUpdate |=> !codeUpdate)
    else $error("Update pulse longer than one cycle");

  // Exactly sixteen accepted falls stand behind every update
  a_tally_sixteen: assert property (@(posedge ref_clk) disable iff (!resetn)
    codeUpdate |-> fallTally == 5'(sdf_pkg::FRAME_BITS))
    else $error("Update without sixteen falling edges");

  // Sequencer counter agrees with the independent tally
  a_tally_match: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == sdf_pkg::SDF_SHIFT |-> fallTally == bitCnt)
    else $error("Bit counter disagrees with edge tally");

  // Counter never passes the last bit while shifting
  a_count_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
    state == sdf_pkg::SDF_SHIFT |-> bitCnt <= sdf_pkg::CNT_LAST)
    else $error("Bit counter beyond the frame length");

  a_select_high_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clkEn && linkSync.frameSelN && state == sdf_pkg::SDF_IDLE) |=>
      $stable(shiftReg) && !codeUpdate)
    else $error("Activity while frame select is high");

  a_shift_on_fall: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clkEn && state == sdf_pkg::SDF_SHIFT && !linkSync.frameSelN && clkFall) |=>
      shiftReg[0] == $past(linkSync.serialData))
    else $error("Data bit not shifted on falling edge");

  a_abort_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
    frameAbort |-> $stable(analogOutputCode) ##1 !codeUpdate)
    else $error("Abort disturbed the output code");

  // Abort only comes from a frame in progress whose select rose
  a_abort_from_shift: assert property (@(posedge ref_clk) disable iff (!resetn)
    frameAbort |-> $past(state) == sdf_pkg::SDF_SHIFT && $past(linkSync.frameSelN))
    else $error("Abort outside a frame in progress");

  // Abort is a single-cycle pulse and never meets an update
  a_abort_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
    frameAbort |-> !codeUpdate ##1 !frameAbort)
    else $error("Abort pulse malformed");

  // Frame start clears the counter
  a_enter_shift: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clkEn && state == sdf_pkg::SDF_IDLE && !linkSync.frameSelN) |=>
      state == sdf_pkg::SDF_SHIFT && bitCnt == sdf_pkg::CNT_RESET)
    else $error("Frame start not taken");

  // Clocks after the complete word change nothing
  a_done_ignores: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clkEn && state == sdf_pkg::SDF_DONE) |=>
      $stable(shiftReg) && $stable(analogOutputCode))
    else $error("Activity after the complete word");

  // Clock enable low freezes the sequencer and the code
  a_freeze_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
    !clkEn |=> $stable(state) && $stable(shiftReg) && $stable(analogOutputCode))
    else $error("State moved while the clock enable was low");

  // Code is zero on the first edge after reset release
  a_reset_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> analogOutputCode == sdf_pkg::CODE_RESET)
    else $error("Output code not zero after reset");

  // Both ends of the ten-bit field come from the right frame bits
  a_code_width: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(codeUpdate) |->
      analogOutputCode[0] == $past(shiftReg[sdf_pkg::CODE_LSB-1]) &&
      analogOutputCode[sdf_pkg::CODE_BITS-1] ==
        $past(shiftReg[sdf_pkg::CODE_LSB+sdf_pkg::CODE_BITS-2]))
    else $error("Code field misplaced in the frame");
endmodule // sdf_frame

// *** verif/sdf_host.sv ***
// Host model driving the three-wire serial link of the frame receiver.
// Assumes the bench calls its tasks; pins move only at falling ref_clk.
module sdf_host (
  input  wire logic ref_clk,
  output logic      frameSelN,
  output logic      serialClk,
  output logic      serialData
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: deselected, link clock parked high
  initial begin
    frameSelN  = 1'b1;
    serialClk  = 1'b1;
    serialData = 1'b0;
  end
  // Released data line toggles so a stale bit can never pass for data
  always @(negedge ref_clk) begin
    if (frameSelN) begin
      serialData <= ~serialData;
    end
  end
  // Half of the 800 ns link period; far below the rate limit
  task automatic half();
    repeat (4) @(negedge ref_clk);
  endtask
  // MSB first; fewer than sixteen bits ends as an abort
  task automatic send(input logic [15:0] w, input int nb);
    frameSelN <= 1'b0;
    half();
    for (int i = 15; i > 15 - nb; i--) begin
      serialData <= w[i];
      serialClk  <= 1'b1;
      half();
      serialClk <= 1'b0;
      half();
    end
    serialClk <= 1'b1;
    half();
    frameSelN <= 1'b1;
    half();
  endtask
  // Clock pulses while deselected, which the receiver must ignore
  task automatic stray(input int n);
    repeat (n) begin
      serialClk <= ~serialClk;
      half();
    end
    serialClk <= 1'b1;
    half();
  endtask
endmodule // sdf_host

// *** verif/sdf_frame_bench.sv ***
// Self-checking bench for the serial frame receiver, host model on the link.
// Assumes ref_clk at 10 MHz; a reference code model is compared per frame.
module sdf_frame_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                          ref_clk, resetn, codeUpdate, frameAbort;
  logic                          frameSelN, serialClk, serialData, clkEn;
  int                            updBefore = 0, abtBefore = 0;
  logic [sdf_pkg::CODE_BITS-1:0] analogOutputCode;
  int                            bad_count = 0, samples_checked = 0, seed = 4;
  int                            expCode = 0, updCount = 0, abortCount = 0;
  sdf_host i_host (.ref_clk(ref_clk), .frameSelN(frameSelN), .serialClk(serialClk),
    .serialData(serialData));
  sdf_frame i_dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
    .frameSelN(frameSelN), .serialClk(serialClk), .serialData(serialData),
    .analogOutputCode(analogOutputCode), .codeUpdate(codeUpdate), .frameAbort(frameAbort));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Pulses counted at the falling edge, clear of the launching edge
  always @(negedge ref_clk) begin
    if (codeUpdate === 1'b1) updCount++;
    if (frameAbort === 1'b1) abortCount++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] expVal);
    samples_checked++;
    if (seen !== expVal) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expVal);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // nb 16 full write, 1..15 abort, 0 stray clocks while deselected
  task automatic doFrame(input logic [15:0] w, input int nb);
    int u;
    int a;
    u = updCount;
    a = abortCount;
    if (nb == 0) i_host.stray(6);
    else i_host.send(w, nb);
    repeat (4) @(negedge ref_clk);
    if (nb == 16) expCode = w[11:2];
    check(16'(updCount - u), {15'h0000, nb == 16});
    check(16'(abortCount - a), {15'h0000, nb > 0 && nb < 16});
    check({6'h00, analogOutputCode}, 16'(expCode));
  endtask
  // Watchdog, several times the expected run
  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end
  initial begin
    clkEn = 1'b1;
    resetn = 1'b0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    check({6'h00, analogOutputCode}, 16'h0000);
    doFrame(16'hffff, 15);
    doFrame(16'hffff, 0);
    for (int k = 0; k < 12; k++) begin
      doFrame(16'($random(seed)), (k % 3 == 2) ? 0 : (k % 3 == 1) ? 16 :
        1 + ($unsigned($random(seed)) % 15));
    end
    // Second reset mid-run: code returns to zero and stays there
    resetn = 1'b0;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    expCode = 0;
    check({6'h00, analogOutputCode}, 16'h0000);
    doFrame(16'hffff, 15);
    // A whole frame sent while frozen must leave no trace
    updBefore = updCount;
    abtBefore = abortCount;
    clkEn = 1'b0;
    i_host.send(16'h5554, 16);
    clkEn = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(16'(updCount - updBefore), 16'h0000);
    check(16'(abortCount - abtBefore), 16'h0000);
    check({6'h00, analogOutputCode}, 16'(expCode));
    doFrame(16'hfffc, 16);
    doFrame(16'h0003, 16);
    finish_test();
  end
endmodule // sdf_frame_bench
